// ---- rtl/mps_supervisor.sv ----
// protection supervisor: bridge override, lock latch, ahb-lite registers
// assumes all inputs synchronous to hclk; one ahb-lite slave, zero wait states
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module mps_supervisor
#(
   parameter int TICK_CYCLES = mps_pkg::TICK_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire mps_pkg::mps_sense_t sense,
   input wire logic hall_differential,
   input wire logic sleep,
   input wire logic lock_release_select,
   input wire logic rotation_direction,
   input wire logic brake_command,
   input wire logic speed_pwm_mode,
   input wire logic speed_command_pwm_low,
   input wire logic speed_command_dc_low,
   input wire mps_pkg::mps_bridge_t drive_request,
   output mps_pkg::mps_bridge_t bridge,
   output logic irq
);

   typedef struct packed {
      logic [15:0] prescale;
      logic [12:0] hall_ticks;
      logic [12:0] lock_ticks;
      mps_pkg::mps_lock_state_t lock_state;
      logic low_supply_lockout;
      logic thermal_off;
      logic hall_prev;
      logic dir_prev;
      logic high_supply_lockout_prev;
      logic ocp_prev;
      logic [1:0] ctrl;
      logic [4:0] irq_status;
      logic [4:0] irq_mask;
      logic wr_pending;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      mps_pkg::mps_bridge_t bridge;
      logic irq;
   } mps_state_t;

   mps_state_t s;
   mps_state_t next_s;

   function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] offset);
      reg_hit = (addr[7:0] == offset) && (addr[31:8] == 24'h000000);
   endfunction

   logic tick;
   logic hall_fall;
   logic dir_change;
   logic speed_low;
   logic auto_release;
   logic forced_release;
   logic lock_declare;
   logic brake_active;
   logic addr_phase;
   logic [4:0] events;
   logic [31:0] status_word;

   always_comb
   begin
      next_s = s;
      // prescaler gives a one-cycle enable per millisecond
      tick = (s.prescale == 16'(TICK_CYCLES - 1));
      next_s.prescale = tick ? 16'h0000 : s.prescale + 16'h0001;

      hall_fall = s.hall_prev & ~hall_differential;
      dir_change = s.dir_prev ^ rotation_direction;
      speed_low = speed_pwm_mode ? speed_command_pwm_low : speed_command_dc_low;
      next_s.hall_prev = hall_differential;
      next_s.dir_prev = rotation_direction;
      next_s.high_supply_lockout_prev = sense.high_supply_lockout;
      next_s.ocp_prev = sense.overcurrent_guard;

      // low supply lockout with hysteresis
      if (sense.supply_at_or_below_low)
      begin
         next_s.low_supply_lockout = 1'b1;
      end
      else if (sense.supply_at_or_above_release)
      begin
         next_s.low_supply_lockout = 1'b0;
      end

      // thermal latch with hysteresis
      if (sense.temp_above_trip)
      begin
         next_s.thermal_off = 1'b1;
      end
      else if (sense.temp_below_release)
      begin
         next_s.thermal_off = 1'b0;
      end

      forced_release = sleep | s.low_supply_lockout;
      auto_release = ~lock_release_select
         & ((s.lock_ticks >= mps_pkg::RELEASE_TICKS)
         | hall_fall
         | speed_low
         | dir_change
         | brake_command);
      lock_declare = 1'b0;

      case (s.lock_state)
         mps_pkg::MPS_RUN:
         begin
            next_s.lock_ticks = 13'h0000;
            if (hall_fall || forced_release || !s.ctrl[mps_pkg::CTRL_LOCK_ENABLE])
            begin
               next_s.hall_ticks = 13'h0000;
            end
            else if (s.hall_ticks >= mps_pkg::LOCK_TICKS)
            begin
               lock_declare = 1'b1;
               next_s.lock_state = mps_pkg::MPS_LOCKED;
            end
            else if (tick)
            begin
               next_s.hall_ticks = s.hall_ticks + 13'h0001;
            end
         end
         mps_pkg::MPS_LOCKED:
         begin
            if (forced_release || auto_release)
            begin
               next_s.lock_state = mps_pkg::MPS_RUN;
               next_s.hall_ticks = 13'h0000;
            end
            else if (tick && s.lock_ticks < mps_pkg::RELEASE_TICKS)
            begin
               next_s.lock_ticks = s.lock_ticks + 13'h0001;
            end
         end
         default:
         begin
            next_s.lock_state = mps_pkg::MPS_RUN;
         end
      endcase

      brake_active = s.low_supply_lockout
         | sense.high_supply_lockout
         | sense.overcurrent_guard
         | (s.lock_state == mps_pkg::MPS_LOCKED)
         | s.ctrl[mps_pkg::CTRL_FORCE_BRAKE];

      if (s.thermal_off)
      begin
         next_s.bridge = '0;
      end
      else if (brake_active)
      begin
         next_s.bridge.upper_on = 3'h0;
         next_s.bridge.lower_on = 3'h7;
      end
      else
      begin
         next_s.bridge = drive_request;
      end

      events = '0;
      events[mps_pkg::EV_LOW_SUPPLY_LOCKOUT] = next_s.low_supply_lockout & ~s.low_supply_lockout;
      events[mps_pkg::EV_HIGH_SUPPLY_LOCKOUT] = sense.high_supply_lockout & ~s.high_supply_lockout_prev;
      events[mps_pkg::EV_OCP] = sense.overcurrent_guard & ~s.ocp_prev;
      events[mps_pkg::EV_LOCK] = lock_declare;
      events[mps_pkg::EV_THERMAL] = next_s.thermal_off & ~s.thermal_off;

      status_word = '0;
      status_word[0] = s.low_supply_lockout;
      status_word[1] = sense.high_supply_lockout;
      status_word[2] = sense.overcurrent_guard;
      status_word[3] = (s.lock_state == mps_pkg::MPS_LOCKED);
      status_word[4] = s.thermal_off;
      status_word[5] = brake_active;
      status_word[6] = lock_release_select;

      // ahb-lite: write data taken in data phase, read data set up at address phase end
      addr_phase = hsel & hready & (htrans == mps_pkg::HTRANS_NONSEQ);
      next_s.wr_pending = addr_phase & hwrite & (haddr[31:8] == 24'h000000);
      next_s.wr_addr = haddr[7:0];
      next_s.rdata = 32'h00000000;
      if (s.wr_pending)
      begin
         if (s.wr_addr == mps_pkg::ADDR_CTRL)
         begin
            next_s.ctrl = hwdata[1:0];
         end
         if (s.wr_addr == mps_pkg::ADDR_IRQ_MASK)
         begin
            next_s.irq_mask = hwdata[4:0];
         end
      end
      if (addr_phase && !hwrite)
      begin
         if (reg_hit(haddr, mps_pkg::ADDR_CTRL))
         begin
            next_s.rdata = {30'h00000000, s.ctrl};
         end
         if (reg_hit(haddr, mps_pkg::ADDR_STATUS))
         begin
            next_s.rdata = status_word;
         end
         if (reg_hit(haddr, mps_pkg::ADDR_IRQ_STATUS))
         begin
            next_s.rdata = {27'h0000000, s.irq_status};
            next_s.irq_status = 5'h00;
         end
         if (reg_hit(haddr, mps_pkg::ADDR_IRQ_MASK))
         begin
            next_s.rdata = {27'h0000000, s.irq_mask};
         end
      end
      // a new event wins over the read clear
      next_s.irq_status = next_s.irq_status | events;
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.ctrl <= mps_pkg::CTRL_RESET;
         s.irq_mask <= mps_pkg::MASK_RESET;
         s.lock_state <= mps_pkg::MPS_RUN;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign hrdata = s.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign bridge = s.bridge;
   assign irq = s.irq;

endmodule

// ---- rtl/mps_pkg.sv ----
// package for the motor protection supervisor: constants, carriers, states
// assumes one 40 MHz clock and comparator flags already digitised
package mps_pkg;

   localparam int CLK_HZ = 40000000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_TIME_US;
   localparam int LOCK_TIME_MS = 500;
   localparam int AUTO_RELEASE_MS = 5000;
   localparam logic [12:0] LOCK_TICKS = 13'(LOCK_TIME_MS * 1000 / TICK_TIME_US);
   localparam logic [12:0] RELEASE_TICKS = 13'(AUTO_RELEASE_MS * 1000 / TICK_TIME_US);

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

   localparam int CTRL_FORCE_BRAKE = 0;
   localparam int CTRL_LOCK_ENABLE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;

   localparam int EV_LOW_SUPPLY_LOCKOUT = 0;
   localparam int EV_HIGH_SUPPLY_LOCKOUT = 1;
   localparam int EV_OCP = 2;
   localparam int EV_LOCK = 3;
   localparam int EV_THERMAL = 4;
   localparam int EV_WIDTH = 5;
   localparam logic [4:0] MASK_RESET = 5'h00;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic {
      MPS_RUN = 1'b0,
      MPS_LOCKED = 1'b1
   } mps_lock_state_t;

   typedef struct packed {
      logic supply_at_or_below_low;
      logic supply_at_or_above_release;
      logic high_supply_lockout;
      logic overcurrent_guard;
      logic temp_above_trip;
      logic temp_below_release;
   } mps_sense_t;

   typedef struct packed {
      logic [2:0] upper_on;
      logic [2:0] lower_on;
   } mps_bridge_t;

endpackage

// ---- testbench/mps_properties.sv ----
// port assertions for the supervisor, bound in from the bench
// assumes TICK_CYCLES equal to the design's
`timescale 1ns/100ps
module mps_properties
#(
   parameter int TICK_CYCLES = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire mps_pkg::mps_sense_t sense,
   input wire logic hall_differential,
   input wire logic sleep,
   input wire logic lock_release_select,
   input wire mps_pkg::mps_bridge_t bridge
);
   localparam int LOCK_CYC = TICK_CYCLES * 500 + 8;
   int gap;
   logic hall_q;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // cycles since the last hall fall with nothing clearing the lock
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         gap <= 0;
         hall_q <= 1'b0;
      end
      else
      begin
         hall_q <= hall_differential;
         gap <= (hall_q && !hall_differential) || sleep || !lock_release_select
            || !sense.supply_at_or_above_release ? 0 : gap + 1;
      end
   low_supply_lockout_brake_a:
      assert property (sense.supply_at_or_below_low |=> ##1 bridge.upper_on == 3'h0)
      else $error("upper on at low supply");
   low_supply_lockout_hold_a:
      assert property ((sense.supply_at_or_below_low ##1 !sense.supply_at_or_above_release [*3])
         |=> bridge.upper_on == 3'h0) else $error("low supply released early");
   brake_pattern_a:
      assert property ((sense.supply_at_or_below_low && sense.temp_below_release) [*3]
         |=> bridge == 6'h07) else $error("wrong brake pattern");
   high_supply_a:
      assert property (sense.high_supply_lockout |=> bridge.upper_on == 3'h0)
      else $error("upper on at high supply");
   overcurrent_a:
      assert property (sense.overcurrent_guard |=> bridge.upper_on == 3'h0)
      else $error("upper on at overcurrent");
   thermal_hold_a:
      assert property ((sense.temp_above_trip ##1 !sense.temp_below_release [*3])
         |=> bridge == 6'h00) else $error("switch on while hot");
   thermal_wins_a:
      assert property (sense.temp_above_trip && sense.overcurrent_guard
         |=> ##1 bridge.lower_on == 3'h0) else $error("brake beat all off");
   lock_brake_a:
      assert property (gap > LOCK_CYC |-> bridge.upper_on == 3'h0 && bridge.lower_on != 3'h0
         || bridge == 6'h00) else $error("no lock brake");
   lock_c: cover property (gap == LOCK_CYC);
   heat_c: cover property (sense.temp_above_trip ##2 bridge == 6'h00);
   ocp_c: cover property (sense.overcurrent_guard ##1 bridge == 6'h07);
endmodule

// ---- testbench/mps_motor_model.sv ----
// fan motor behind the bridge, giving the hall comparator output
// turns while an upper switch is on unless stalled; spin turns it from outside
`timescale 1ns/100ps
module mps_motor_model
(
   input wire logic hclk,
   input wire mps_pkg::mps_bridge_t bridge,
   input wire logic stall,
   input wire logic spin,
   output logic hall_differential
);
   logic [2:0] phase = 3'h0;
   always @(posedge hclk)
      if ((|bridge.upper_on && !stall) || spin)
         phase <= phase + 3'h1;
   assign hall_differential = phase[2];
endmodule

// ---- testbench/test_motor_protection_supervisor.sv ----
// bench: supervisor, motor model, bus master tasks
// assumes hready is the slave's hreadyout; TICK_CYCLES cut to 4
`timescale 1ns/100ps
module test_motor_protection_supervisor;
   logic hclk, hresetn, hwrite, hrdy, irq, hall, sleep, sel, dir, brk, pmode, plow, dlow;
   logic stall, spin;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, bw;
   mps_pkg::mps_sense_t sense;
   mps_pkg::mps_bridge_t bridge;
   int n_mismatch, n_checks;
   logic [11:0] rows [11] = '{{6'h11, 6'h21},
      {6'h19, 6'h07},
      {6'h15, 6'h07},
      {6'h11, 6'h21},
      {6'h21, 6'h07},
      {6'h01, 6'h07},
      {6'h11, 6'h21},
      {6'h12, 6'h00},
      {6'h16, 6'h00},
      {6'h14, 6'h00},
      {6'h11, 6'h21}};
   assign bw = {26'h0, bridge};
   mps_supervisor #(.TICK_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(), .sense(sense),
      .hall_differential(hall), .sleep(sleep), .lock_release_select(sel),
      .rotation_direction(dir), .brake_command(brk), .speed_pwm_mode(pmode),
      .speed_command_pwm_low(plow), .speed_command_dc_low(dlow), .drive_request(6'h21),
      .bridge(bridge), .irq(irq));
   mps_motor_model motor (.hclk(hclk), .bridge(bridge), .stall(stall), .spin(spin),
      .hall_differential(hall));
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wait_ready();
      int i;
      for (i = 0; i == 0 || (hrdy !== 1'b1 && i < 16); i++)
         @(posedge hclk);
      if (hrdy !== 1'b1)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d = 32'h1f);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= mps_pkg::HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic lock_up();
      int i;
      stall <= 1'b1;
      tick(1900);
      check("early lock", 32'h21, bw);
      for (i = 0; i < 300 && bridge !== 6'h07; i++)
         tick(1);
      check("lock", 32'h07, bw);
   endtask
   task automatic fire(input int e);
      spin <= (e == 0);
      plow <= (e == 1);
      dlow <= (e == 1);
      dir <= dir ^ (e == 2);
      brk <= (e == 3);
      sleep <= (e == 4);
      sense <= (e == 5) ? 6'h21 : 6'h11;
      tick(20);
      {spin, plow, dlow, brk, sleep, stall} <= 6'h0;
      sense <= 6'h11;
      tick(40);
   endtask
   initial
   begin
      hresetn = 1'b0;
      {htrans, haddr, hwrite, hwdata} = '0;
      sense = 6'h11;
      {sleep, sel, dir, brk, pmode, plow, dlow, stall, spin} = 9'h0;
      n_mismatch = 0;
      n_checks = 0;
      tick(3);
      check("reset bridge", 32'h0, bw);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         sense <= rows[i][11:6];
         tick(8);
         check("bridge", {26'h0, rows[i][5:0]}, bw);
      end
      check("irq masked", 32'h0, {31'h0, irq});
      bus(mps_pkg::ADDR_IRQ_MASK, 1'b1);
      tick(2);
      check("irq", 32'h1, {31'h0, irq});
      bus(mps_pkg::ADDR_IRQ_STATUS, 1'b0);
      check("irq status", 32'h17, rd);
      bus(mps_pkg::ADDR_IRQ_STATUS, 1'b0);
      check("irq cleared", 32'h0, rd);
      bus(8'h10, 1'b0);
      check("unmapped", 32'h0, rd);
      bus(mps_pkg::ADDR_CTRL, 1'b0);
      check("ctrl", 32'h2, rd);
      check("irq low", 32'h0, {31'h0, irq});
      bus(mps_pkg::ADDR_CTRL, 1'b1, 32'h3);
      tick(3);
      check("force brake", 32'h07, bw);
      bus(mps_pkg::ADDR_STATUS, 1'b0);
      check("status", 32'h20, rd);
      bus(mps_pkg::ADDR_CTRL, 1'b1, 32'h2);
      tick(3);
      check("drive back", 32'h21, bw);
      for (int s = 1; s >= 0; s--)
         for (int e = 0; e < 6; e++)
         begin
            sel <= s[0];
            pmode <= s[0];
            if (s == 0 || e == 0 || e == 5)
               lock_up();
            fire(e);
            check("release", (s == 1 && e < 4) ? 32'h07 : 32'h21, bw);
         end
      lock_up();
      tick(19000);
      check("held", 32'h07, bw);
      for (int i = 0; i < 1100 && bridge !== 6'h21; i++)
         tick(1);
      check("auto release", 32'h21, bw);
      give_verdict();
   end
endmodule
bind mps_supervisor mps_properties #(.TICK_CYCLES(TICK_CYCLES)) props (.hclk(hclk),
   .hresetn(hresetn), .sense(sense), .hall_differential(hall_differential), .sleep(sleep),
   .lock_release_select(lock_release_select), .bridge(bridge));
